// ### ppf_params.svh
// Constants for the pin function block: register offsets, field positions, reset values, timing counts.
// Assumes a 100 MHz system clock; included by bare name.
`ifndef PPF_PARAMS_SVH
`define PPF_PARAMS_SVH

// Register offsets (byte addresses)
`define PPF_OFF_CFG        8'h00
`define PPF_OFF_GPIO_OUT   8'h04
`define PPF_OFF_GPIO_OE    8'h08
`define PPF_OFF_PIN_IN     8'h0C
`define PPF_OFF_IRQ_STAT   8'h10
`define PPF_OFF_IRQ_MASK   8'h14
`define PPF_OFF_STATE      8'h18
`define PPF_OFF_BLINK      8'h1C

// Configuration fields
`define PPF_CFG_CLK_GPIO   0
`define PPF_CFG_LED_GPIO   1
`define PPF_CFG_IRQ_MODE   2
`define PPF_CFG_RESET      8'h00

// Status / mask bit positions
`define PPF_EV_LINK_UP     0
`define PPF_EV_LINK_DOWN   1
`define PPF_EV_PWRDN       2
`define PPF_EV_TX_START    3
`define PPF_EV_COUNT       4

// Blink half period in ms, and its cycle count at 100 MHz
`define PPF_BLINK_MS       50
`define PPF_CLK_HZ         100000000
// Divide first: the product would overflow a 32-bit integer
`define PPF_BLINK_CYC      ((`PPF_CLK_HZ / 1000) * `PPF_BLINK_MS)
`define PPF_BLINK_W        24

// Edges after reset release before the strap is frozen
`define PPF_STRAP_HOLD     2'h3

`endif

// ### ppf_pkg.sv
// Types shared by the pin function block.
// Assumes ppf_params.svh is compiled alongside.
package ppf_pkg;
    // Function of the interrupt / power-down pin
    typedef enum logic [1:0] {
        PPF_PIN_PWRDN = 2'h1,
        PPF_PIN_IRQ   = 2'h2
    } ppf_irqpin_t;
endpackage : ppf_pkg

// ### ppf_blink_if.sv
// Interface between the top and the activity blinker.
// Assumes one clock domain, clk_sys.
`timescale 1ns/10ps
interface ppf_blink_if;
    logic                  link_good;
    logic                  active;
    logic [23:0]           half_period;
    logic                  led_on;
    modport src (output link_good, output active, output half_period, input led_on);
    modport blk (input link_good, input active, input half_period, output led_on);
endinterface : ppf_blink_if

// ### ppf_sync.sv
// Two-flop synchroniser vector for pin inputs.
// Assumes pins are asynchronous to clk_sys.
`timescale 1ns/10ps
module ppf_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;
    // First flop is read only by the second
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule : ppf_sync

// ### ppf_blink.sv
// Link / activity indicator: steady on with link, blinking with traffic.
// Assumes synchronous inputs on clk_sys.
`timescale 1ns/10ps
`include "ppf_params.svh"
module ppf_blink (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    // Control and result
    ppf_blink_if.blk  bl
);
    logic [23:0] cnt;
    logic [23:0] next_cnt;
    logic        phase;
    logic        next_phase;
    logic        led;
    logic        next_led;

    // Blink phase runs only while traffic is seen
    always_comb begin
        next_cnt   = cnt;
        next_phase = phase;
        if (!bl.active) begin
            next_cnt   = '0;
            next_phase = 1'b0;
        end else if (cnt + 24'h000001 >= bl.half_period) begin
            next_cnt   = '0;
            next_phase = ~phase;
        end else begin
            next_cnt = cnt + 24'h000001;
        end
        // Off with link down; activity overrides steady on
        if (!bl.link_good)
            next_led = 1'b0;                          // RQ15
        else if (bl.active)
            next_led = ~next_phase;                   // RQ12
        else
            next_led = 1'b1;                          // RQ11
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt   <= '0;
            phase <= 1'b0;
            led   <= 1'b0;
        end else begin
            cnt   <= next_cnt;
            phase <= next_phase;
            led   <= next_led;
        end
    end

    assign bl.led_on = led;
endmodule : ppf_blink

// ### ppf_top.sv
// Pin function logic: clock-out / second indicator / GPIO pin, interrupt or power-down pin,
// link activity indicator pin, transmit data qualification and a small register file.
// Assumes clk_sys at 100 MHz is the reference clock; pins are asynchronous and synchronised here.
// Limitation: power-down is only reported on a port.
`timescale 1ns/10ps
`include "ppf_params.svh"

// Functional notes
// RQ1 - MAC drives transmit enable active high, aligned to reference clock rising edge.
// RQ2 - Transmit data counts as valid only while transmit enable is high.
// RQ3 - Master mode: clock/indicator pin outputs the 50 MHz reference by default.
// RQ4 - Slave mode: clock/indicator pin acts as second status indicator by default.
// RQ5 - A register setting turns the clock/indicator pin into a GPIO.
// RQ6 - After reset the interrupt/power-down pin is a power-down input.
// RQ7 - Pin becomes interrupt output only after host writes the configuration register.
// RQ8 - As power-down input, a low level puts the whole device in power-down.
// RQ9 - As interrupt output, pin drives low while an enabled interrupt is pending.
// RQ10 - Interrupt pin only pulls low or releases, never drives high.
// RQ11 - Link indicator stays on while link is good.
// RQ12 - Link indicator blinks while transmitter or receiver is active.
// RQ13 - A register setting turns the link indicator pin into a GPIO.
// RQ14 - Reset held low 25 us resamples straps and restores default functions.
// RQ15 - Blink period is configurable from the clock; indicator off with link down.
module ppf_top (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Strap and reference clock for the clock-out path
    input  wire logic        rmii_master_strap,
    input  wire logic        ref_clk_50m,
    // RMII transmit side
    input  wire logic        tx_en,
    input  wire logic [1:0]  tx_d,
    output logic      [1:0]  tx_data,
    output logic             tx_data_valid,
    // Core status
    input  wire logic        link_good,
    input  wire logic        rx_active,
    input  wire logic        second_status,
    output logic             powerdown,
    // Clock / second indicator pin
    input  wire logic        clock_or_second_indicator_pin_i,
    output logic             clock_or_second_indicator_pin_o,
    output logic             clock_or_second_indicator_pin_oe,
    // Interrupt / power-down pin
    input  wire logic        irq_or_powerdown_pin_i,
    output logic             irq_or_powerdown_pin_o,
    output logic             irq_or_powerdown_pin_oe,
    // Link activity indicator pin
    input  wire logic        link_activity_indicator_i,
    output logic             link_activity_indicator_o,
    output logic             link_activity_indicator_oe,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // Interrupt to the system
    output logic             irq
);
    // Sets status and mask widths
    localparam int NEV = `PPF_EV_COUNT;

    // Synchronised pins; tx signals come from the MAC on the reference clock domain
    logic [4:0] pins_s;
    ppf_sync #(.W(5)) u_sync (
        .clk_sys (clk_sys),
        .rst     (rst),
        // Inverted: flop reset value then means idle high
        .d       ({tx_en, tx_d, ~irq_or_powerdown_pin_i, rmii_master_strap}),
        .q       (pins_s)
    );

    // Readback only, no edges taken
    logic [1:0] pins_s2;
    ppf_sync #(.W(2)) u_sync2 (
        .clk_sys (clk_sys),
        .rst     (rst),
        .d       ({clock_or_second_indicator_pin_i, link_activity_indicator_i}),
        .q       (pins_s2)
    );
    logic       tx_en_s;
    logic [1:0] tx_d_s;
    logic       pd_pin_s;
    logic       strap_s;

    // Slices of the synchronised word
    assign tx_en_s  = pins_s[4];                      // RQ1
    assign tx_d_s   = pins_s[3:2];
    assign pd_pin_s = ~pins_s[1];                     // Pin polarity
    assign strap_s  = pins_s[0];

    // Register state
    logic [7:0]      cfg;
    logic [1:0]      gpio_out;
    logic [1:0]      gpio_oe;
    logic [NEV-1:0]  stat;
    logic [NEV-1:0]  mask;
    logic [23:0]     blink_half;
    logic            master;
    logic [1:0]      strap_cnt;
    logic [31:0]     rdata;

    // Next values
    logic [7:0]      next_cfg;
    logic [1:0]      next_gpio_out;
    logic [1:0]      next_gpio_oe;
    logic [NEV-1:0]  next_stat;
    logic [NEV-1:0]  next_mask;
    logic [23:0]     next_blink_half;
    logic            next_master;
    logic [1:0]      next_strap_cnt;
    logic [31:0]     next_rdata;

    // Transmit path and event tracking
    logic [1:0]      txd_q;
    logic            txv_q;
    logic            link_q;
    logic            pd_q;
    logic [1:0]      next_txd_q;
    logic            next_txv_q;
    logic            next_pd_q;

    // Pin function and events
    ppf_pkg::ppf_irqpin_t pin_fn;
    logic [NEV-1:0]  ev;
    logic            pending;

    // Pin function decided by configuration; reset leaves it as power-down input
    // Only the mode bit moves it
    assign pin_fn  = cfg[`PPF_CFG_IRQ_MODE] ? ppf_pkg::PPF_PIN_IRQ : ppf_pkg::PPF_PIN_PWRDN; // RQ6 RQ7
    // Shared by irq and the pin
    assign pending = |(stat & mask);

    // Event sources
    // Edges against registered copies
    assign ev[`PPF_EV_LINK_UP]   = link_good & ~link_q;
    assign ev[`PPF_EV_LINK_DOWN] = ~link_good & link_q;
    assign ev[`PPF_EV_PWRDN]     = next_pd_q & ~pd_q;
    assign ev[`PPF_EV_TX_START]  = next_txv_q & ~txv_q;

    // Transmit qualification and power-down sampling
    // Zero data outside enable: nothing stale leaks
    always_comb begin
        next_txv_q = tx_en_s;
        next_txd_q = tx_en_s ? tx_d_s : 2'h0;             // RQ2
        next_pd_q  = (pin_fn == ppf_pkg::PPF_PIN_PWRDN) && !pd_pin_s; // RQ8
    end

    // Transmit and edge registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            txd_q  <= 2'h0;
            txv_q  <= 1'b0;
            pd_q   <= 1'b0;
            link_q <= 1'b0;
        end else begin
            txd_q  <= next_txd_q;
            txv_q  <= next_txv_q;
            pd_q   <= next_pd_q;
            link_q <= link_good;
        end
    end

    // Straight from flops
    assign tx_data       = txd_q;
    assign tx_data_valid = txv_q;
    assign powerdown     = pd_q;

    // Register writes, sticky status (set wins over clear), read data one cycle later
    // No wait states
    always_comb begin
        next_cfg         = cfg;
        next_gpio_out    = gpio_out;
        next_gpio_oe     = gpio_oe;
        next_mask        = mask;
        next_blink_half  = blink_half;
        next_master      = master;
        next_strap_cnt   = strap_cnt;
        next_stat        = stat;
        next_rdata       = 32'h0000_0000;

        // Strap followed until the synchroniser settles, then frozen;
        // the first two edges would only see the flops' reset value
        if (strap_cnt != `PPF_STRAP_HOLD) begin
            next_master    = strap_s;                     // RQ14
            next_strap_cnt = strap_cnt + 2'h1;
        end

        // Unmapped writes change nothing
        if (reg_wr) begin
            case (reg_addr)
                `PPF_OFF_CFG:      next_cfg        = reg_wdata[7:0];          // RQ5 RQ7 RQ13
                `PPF_OFF_GPIO_OUT: next_gpio_out   = reg_wdata[1:0];
                `PPF_OFF_GPIO_OE:  next_gpio_oe    = reg_wdata[1:0];
                `PPF_OFF_IRQ_STAT: next_stat       = stat & ~reg_wdata[NEV-1:0];
                `PPF_OFF_IRQ_MASK: next_mask       = reg_wdata[NEV-1:0];
                `PPF_OFF_BLINK:    next_blink_half = reg_wdata[23:0];         // RQ15
                default:           next_cfg        = cfg;
            endcase
        end
        // After the write: a clear never hides an event
        next_stat = next_stat | ev;

        // Stands only in the cycle after the strobe
        if (reg_rd) begin
            case (reg_addr)
                `PPF_OFF_CFG:      next_rdata = {24'h000000, cfg};
                `PPF_OFF_GPIO_OUT: next_rdata = {30'h00000000, gpio_out};
                `PPF_OFF_GPIO_OE:  next_rdata = {30'h00000000, gpio_oe};
                `PPF_OFF_PIN_IN:   next_rdata = {29'h00000000, pd_pin_s, pins_s2};
                `PPF_OFF_IRQ_STAT: next_rdata = {28'h0000000, stat};
                `PPF_OFF_IRQ_MASK: next_rdata = {28'h0000000, mask};
                `PPF_OFF_STATE:    next_rdata = {28'h0000000, pending, pd_q, link_q, master};
                `PPF_OFF_BLINK:    next_rdata = {8'h00, blink_half};
                default:           next_rdata = 32'h0000_0000;
            endcase
        end
    end

    // Register file; reset restores all functions
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cfg         <= `PPF_CFG_RESET;
            gpio_out    <= 2'h0;
            gpio_oe     <= 2'h0;
            stat        <= '0;
            mask        <= '0;
            blink_half  <= 24'(`PPF_BLINK_CYC);
            master      <= 1'b0;
            strap_cnt   <= 2'h0;
            rdata       <= 32'h0000_0000;
        end else begin
            cfg         <= next_cfg;
            gpio_out    <= next_gpio_out;
            gpio_oe     <= next_gpio_oe;
            stat        <= next_stat;
            mask        <= next_mask;
            blink_half  <= next_blink_half;
            master      <= next_master;
            strap_cnt   <= next_strap_cnt;
            rdata       <= next_rdata;
        end
    end

    // Read data and level interrupt
    assign reg_rdata = rdata;
    assign irq       = pending;

    // Activity blinker
    // Registered link, in step with link events
    ppf_blink_if bl ();
    assign bl.link_good   = link_q;
    assign bl.active      = txv_q | rx_active;
    assign bl.half_period = blink_half;
    ppf_blink u_blink (
        .clk_sys (clk_sys),
        .rst     (rst),
        .bl      (bl)
    );

    // Pin output registers; the reference clock is passed straight through, not retimed
    // Retiming 50 MHz on 100 MHz would distort it
    logic sec_q;
    logic led_q;
    logic irq_oe_q;
    logic next_sec_q;
    logic next_led_q;
    logic next_irq_oe_q;

    // GPIO override first, then the function
    always_comb begin
        next_sec_q    = cfg[`PPF_CFG_CLK_GPIO] ? gpio_out[0] : second_status;  // RQ4 RQ5
        next_led_q    = cfg[`PPF_CFG_LED_GPIO] ? gpio_out[1] : bl.led_on;     // RQ13
        next_irq_oe_q = (pin_fn == ppf_pkg::PPF_PIN_IRQ) && pending;          // RQ9
    end

    // Pin registers; pull-down off in reset
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sec_q    <= 1'b0;
            led_q    <= 1'b0;
            irq_oe_q <= 1'b0;
        end else begin
            sec_q    <= next_sec_q;
            led_q    <= next_led_q;
            irq_oe_q <= next_irq_oe_q;
        end
    end

    // Clock/indicator pin: clock only in master mode without GPIO override
    assign clock_or_second_indicator_pin_o  = (master && !cfg[`PPF_CFG_CLK_GPIO]) ? ref_clk_50m : sec_q; // RQ3
    // Enable register decides only in GPIO mode
    assign clock_or_second_indicator_pin_oe = cfg[`PPF_CFG_CLK_GPIO] ? gpio_oe[0] : 1'b1;

    // Open drain: data fixed low, enable pulls the line
    assign irq_or_powerdown_pin_o           = 1'b0;                  // RQ10
    assign irq_or_powerdown_pin_oe          = irq_oe_q;              // RQ10
    // GPIO value or blinker, both registered
    assign link_activity_indicator_o        = led_q;
    assign link_activity_indicator_oe       = cfg[`PPF_CFG_LED_GPIO] ? gpio_oe[1] : 1'b1;
endmodule : ppf_top

// ### ppf_top_sva.sv
// Checker for the pin function block, watching only the top-level ports.
// Assumes one clock domain, clk_sys, with rst active high and asynchronous.
`timescale 1ns/10ps
module ppf_top_sva (
    // Clock and reset
    input logic        clk_sys,
    input logic        rst,
    // Transmit side
    input logic        tx_en,
    input logic [1:0]  tx_d,
    input logic [1:0]  tx_data,
    input logic        tx_data_valid,
    // Status and pins
    input logic        link_good,
    input logic        rx_active,
    input logic        powerdown,
    input logic        irq_or_powerdown_pin_i,
    input logic        irq_or_powerdown_pin_o,
    input logic        irq_or_powerdown_pin_oe,
    input logic        link_activity_indicator_o,
    input logic        irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Quiet link and busy link, each held over several cycles
    sequence link_idle; (link_good && !rx_active && !tx_en)[*5]; endsequence
    sequence link_busy; (link_good && rx_active)[*8]; endsequence

    AST_IRQ_PIN_NEVER_HIGH: assert property (!irq_or_powerdown_pin_o)
        else $error("Interrupt pin output value is high");
    AST_IRQ_PIN_CAUSE: assert property (irq_or_powerdown_pin_oe |-> $past(irq))
        else $error("Interrupt pin pulled low with nothing pending");
    AST_IRQ_PIN_RESET_OFF: assert property ($fell(rst) |-> !irq_or_powerdown_pin_oe [*4])
        else $error("Interrupt pin driven right after reset");
    AST_PD_CAUSE: assert property (powerdown |-> !$past(irq_or_powerdown_pin_i, 3))
        else $error("Power-down without a low pin");
    AST_PD_NOT_IRQ: assert property (irq_or_powerdown_pin_oe |-> !powerdown)
        else $error("Power-down while pin is an interrupt output");
    AST_TX_VALID: assert property (tx_data_valid == $past(tx_en, 3))
        else $error("Transmit valid does not follow transmit enable");
    AST_TX_DATA: assert property (tx_data_valid |-> tx_data == $past(tx_d, 3))
        else $error("Transmit data corrupted");
    AST_TX_GATED: assert property (!tx_data_valid |-> tx_data == 2'h0)
        else $error("Transmit data leaks outside enable");
    AST_LED_STEADY: assert property (link_idle |-> link_activity_indicator_o)
        else $error("Indicator not steady on with quiet link");
    AST_LED_BLINK: assert property (link_busy |-> ##[0:5]
        (link_activity_indicator_o != $past(link_activity_indicator_o)))
        else $error("Indicator not blinking with activity");
endmodule : ppf_top_sva

bind ppf_top ppf_top_sva i_sva (.clk_sys, .rst, .tx_en, .tx_d, .tx_data, .tx_data_valid, .link_good,
    .rx_active, .powerdown, .irq_or_powerdown_pin_i, .irq_or_powerdown_pin_o, .irq_or_powerdown_pin_oe,
    .link_activity_indicator_o, .irq);

// ### ppf_mac_host_model.sv
// Far-side model: a MAC sending one byte as dibits, and the host side of the shared pin.
// Assumes clk_sys is the shared reference clock; the pin has a pull-up.
`timescale 1ns/10ps
module ppf_mac_host_model (
    // Clock
    input  logic       clk_sys,
    // Requests from the bench
    input  logic       send,
    input  logic [7:0] frame_byte,
    input  logic       pd_req,
    // Shared pin, device side
    input  logic       pin_oe,
    input  logic       pin_o,
    output logic       pin_level,
    // Transmit lines
    output logic       tx_en,
    output logic [1:0] tx_d
);
    logic [2:0] left = 3'h0;
    logic [7:0] sh   = 8'h00;
    initial tx_en = 1'b0;
    initial tx_d  = 2'h0;
    // Dibits low first on rising edges; idle data toggles so gating is exercised
    always @(posedge clk_sys) begin
        if (send) begin
            sh   <= frame_byte;
            left <= 3'h4;
        end else if (left != 3'h0) begin
            tx_en <= 1'b1;
            tx_d  <= sh[1:0];
            sh    <= sh >> 2;
            left  <= left - 3'h1;
        end else begin
            tx_en <= 1'b0;
            tx_d  <= ~tx_d;
        end
    end
    // Open-drain wire with pull-up; host may pull low too
    assign pin_level = (pin_oe ? pin_o : 1'b1) & ~pd_req;
endmodule : ppf_mac_host_model

// ### phy_pin_function_control_tb_top.sv
// Self-checking bench for the pin function block.
// Assumes ppf_params.svh, the design, the checker and the far-side model are compiled.
`timescale 1ns/10ps
`include "ppf_params.svh"
module phy_pin_function_control_tb_top;
    typedef struct packed { logic [7:0] a; logic [31:0] e; } ppf_row_t;
    logic        clk_sys = 1'b0, rst = 1'b1, rmii_master_strap = 1'b1, ref_clk_50m = 1'b0;
    logic        link_good = 1'b0, rx_active = 1'b0, second_status = 1'b0, send = 1'b0;
    logic        pd_req = 1'b0, clk_ext = 1'b0, led_ext = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0]  frame_byte = 8'h00, reg_addr = 8'h00, got;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, v;
    logic [1:0]  tx_d, tx_data;
    logic        tx_en, tx_data_valid, powerdown, irq, clk_i, clk_o, clk_oe, pd_pin, pd_o, pd_oe;
    logic        led_i, led_o, led_oe, prev;
    int          failures = 0, compares = 0, cyc = 0, n;
    ppf_row_t    rows [8] = '{'{`PPF_OFF_CFG, `PPF_CFG_RESET}, '{`PPF_OFF_GPIO_OUT, 32'h0},
        '{`PPF_OFF_GPIO_OE, 32'h0}, '{`PPF_OFF_IRQ_STAT, 32'h0}, '{`PPF_OFF_IRQ_MASK, 32'h0},
        '{`PPF_OFF_STATE, 32'h1}, '{`PPF_OFF_BLINK, `PPF_BLINK_CYC}, '{8'h20, 32'h0}};

    // Clocks; the 50 MHz reference is unrelated to sampling points
    always #5 clk_sys = ~clk_sys;
    always #10 ref_clk_50m = ~ref_clk_50m;
    // Pins without a driver fall back to the external level
    assign clk_i = clk_oe ? clk_o : clk_ext;
    assign led_i = led_oe ? led_o : led_ext;

    ppf_top i_dut (.clk_sys, .rst, .rmii_master_strap, .ref_clk_50m, .tx_en, .tx_d, .tx_data,
        .tx_data_valid, .link_good, .rx_active, .second_status, .powerdown,
        .clock_or_second_indicator_pin_i(clk_i), .clock_or_second_indicator_pin_o(clk_o),
        .clock_or_second_indicator_pin_oe(clk_oe), .irq_or_powerdown_pin_i(pd_pin),
        .irq_or_powerdown_pin_o(pd_o), .irq_or_powerdown_pin_oe(pd_oe), .link_activity_indicator_i(led_i),
        .link_activity_indicator_o(led_o), .link_activity_indicator_oe(led_oe), .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .irq);
    ppf_mac_host_model i_far (.clk_sys, .send, .frame_byte, .pd_req, .pin_oe(pd_oe), .pin_o(pd_o),
        .pin_level(pd_pin), .tx_en, .tx_d);

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic step(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask : step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    // Read data stands only in the cycle after the strobe
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask : rdchk
    task automatic close_out;
        $display("Compares %0d, mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : close_out

    // Hang guard, well above the expected run length
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 6000) begin
            failures++;
            close_out;
        end
    end

    initial begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        step(8);
        wr(8'h24, 32'hFFFF_FFFF); // Unmapped write must be dropped
        foreach (rows[i]) rdchk(rows[i].a, rows[i].e);
        repeat (2) begin
            #10 chk(32'({clk_o, clk_oe}), 32'({ref_clk_50m, 1'b1}));
        end
        $display("Test defaults done");
        @(posedge clk_sys);
        send       <= 1'b1;
        frame_byte <= 8'hB4;
        @(posedge clk_sys);
        send <= 1'b0;
        #1 n = 0;
        while (tx_data_valid !== 1'b1 && n < 20) begin
            step(1);
            n++;
        end
        repeat (4) begin
            got = {tx_data, got[7:2]};
            step(1);
        end
        chk(32'(got), 32'hB4);
        chk(32'({tx_data_valid, tx_data}), 32'h0);
        wr(`PPF_OFF_IRQ_STAT, 32'hF);
        $display("Test transmit done");
        wr(`PPF_OFF_IRQ_MASK, 32'h3);
        @(posedge clk_sys);
        link_good <= 1'b1;
        step(4);
        chk(32'({irq, pd_oe, pd_pin}), 32'h5);
        wr(`PPF_OFF_CFG, 32'h4);
        step(2);
        chk(32'({pd_oe, pd_pin, powerdown}), 32'h4);
        wr(`PPF_OFF_IRQ_MASK, 32'h0);
        step(2);
        chk(32'({irq, pd_oe}), 32'h0);
        wr(`PPF_OFF_IRQ_MASK, 32'h3);
        link_good <= 1'b0;
        step(4);
        rdchk(`PPF_OFF_IRQ_STAT, 32'h3);
        wr(`PPF_OFF_IRQ_STAT, 32'h1);
        rdchk(`PPF_OFF_IRQ_STAT, 32'h2);
        chk(32'(pd_oe), 32'h1);
        wr(`PPF_OFF_IRQ_STAT, 32'h2);
        step(2);
        chk(32'({irq, pd_oe, pd_pin}), 32'h1);
        wr(`PPF_OFF_CFG, 32'h0);
        $display("Test interrupt done");
        @(posedge clk_sys);
        pd_req <= 1'b1;
        step(5);
        chk(32'(powerdown), 32'h1);
        rdchk(`PPF_OFF_STATE, 32'h5);
        pd_req <= 1'b0;
        step(5);
        chk(32'(powerdown), 32'h0);
        rdchk(`PPF_OFF_IRQ_STAT, 32'h4);
        wr(`PPF_OFF_IRQ_STAT, 32'hF);
        wr(`PPF_OFF_CFG, 32'h4);
        pd_req <= 1'b1;
        step(5);
        chk(32'({powerdown, pd_oe}), 32'h0);
        pd_req <= 1'b0;
        step(5);
        wr(`PPF_OFF_CFG, 32'h0);
        $display("Test powerdown done");
        wr(`PPF_OFF_BLINK, 32'h4);
        #1 chk(32'(led_o), 32'h0);
        link_good <= 1'b1;
        step(6);
        chk(32'(led_o), 32'h1);
        rx_active <= 1'b1;
        step(4);
        prev = led_o;
        n = 0;
        repeat (40) begin
            step(1);
            if (led_o !== prev) n++;
            prev = led_o;
        end
        chk(32'(n >= 9 && n <= 10), 32'h1);
        rx_active <= 1'b0;
        step(6);
        chk(32'(led_o), 32'h1);
        link_good <= 1'b0;
        step(6);
        chk(32'(led_o), 32'h0);
        $display("Test indicator done");
        link_good <= 1'b1;
        step(6);
        wr(`PPF_OFF_GPIO_OUT, 32'h3);
        wr(`PPF_OFF_GPIO_OE, 32'h0);
        wr(`PPF_OFF_CFG, 32'h3);
        step(3);
        chk(32'({clk_oe, led_oe, clk_o, led_o}), 32'h3);
        clk_ext <= 1'b1;
        step(4);
        rdchk(`PPF_OFF_PIN_IN, 32'h6);
        wr(`PPF_OFF_GPIO_OE, 32'h3);
        step(2);
        chk(32'({clk_oe, led_oe}), 32'h3);
        $display("Test general purpose done");
        link_good         <= 1'b0;
        rmii_master_strap <= 1'b0;
        rst               <= 1'b1;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        step(8);
        for (int s = 1; s >= 0; s--) begin
            second_status <= s[0];
            step(2);
            chk(32'({clk_o, clk_oe}), 32'({s[0], 1'b1}));
        end
        rdchk(`PPF_OFF_CFG, `PPF_CFG_RESET);
        rdchk(`PPF_OFF_STATE, 32'h0);
        $display("Test slave reset done");
        close_out;
    end
endmodule : phy_pin_function_control_tb_top
